/* shared/acbc_defs.svh */
// constants of the converter control block: control word layout, reset values, timing
// assumes a 125 MHz system clock; included by the tick timer and the control block
`ifndef ACBC_DEFS_SVH
`define ACBC_DEFS_SVH
`define ACBC_BIT_PD_HI 7
`define ACBC_BIT_PD_LO 6
`define ACBC_BIT_ACQ 5
`define ACBC_BIT_SGL 4
`define ACBC_BIT_UNI 3
`define ACBC_ADDR_MSB 2
`define ACBC_ADDR_LSB 0
`define ACBC_WORD_RESET 8'hC0
`define ACBC_PINS_RESET 4'h7
`define ACBC_CLK_NS 8
`define ACBC_T_CONV_NS 3600
`define ACBC_CONV_STEPS 8'h0D
`define ACBC_TICK_CYC ((`ACBC_T_CONV_NS / 13) / `ACBC_CLK_NS)
`define ACBC_T_ACQ_NS 1000
`define ACBC_ACQ_INT_CYC (`ACBC_T_ACQ_NS / `ACBC_CLK_NS)
`define ACBC_ACQ_EXT_TICKS 8'h03
`endif

/* shared/acbc_pkg.sv */
// types of the converter control block
// assumes acbc_defs.svh is on the include path
package acbc_pkg;
  typedef enum logic [1:0] {ACBC_PD_FULL, ACBC_PD_STANDBY, ACBC_RUN_INTCLK, ACBC_RUN_EXTCLK} acbc_power_type;
  typedef enum logic [1:0] {ACBC_IDLE, ACBC_ACQ_INT, ACBC_ACQ_EXT, ACBC_CONVERT} acbc_phase_type;
  typedef struct packed {
    logic [3:0] s0;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] pins;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] word;
    logic clock_external;
    acbc_phase_type phase;
    logic done_n;
    logic [9:0] result;
    logic [7:0] dout;
  } acbc_ctrl_state_type;
  typedef struct packed {
    logic [7:0] div;
    logic [7:0] remain;
  } acbc_timer_state_type;
endpackage

/* shared/acbc_timer_if.sv */
// carrier between the control sequencer and its tick timer
// both ends run on the same system clock
interface acbc_timer_if;
  logic load;
  logic [7:0] load_count;
  logic by_clock;
  logic use_internal;
  logic ext_fall;
  logic tick;
  logic expired;
  modport ctrl (output load, load_count, by_clock, use_internal, ext_fall, input tick, expired);
  modport timer (input load, load_count, by_clock, use_internal, ext_fall, output tick, expired);
endinterface

/* logic/acbc_tick_timer.sv */
// conversion clock source and interval counter
// assumes ext_fall is already synchronised and gated by chip select
`include "acbc_defs.svh"
module acbc_tick_timer
  import acbc_pkg::*;
#(
  parameter int unsigned TICK_CYC = `ACBC_TICK_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  acbc_timer_if.timer tmr
);
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
  acbc_timer_state_type cur;
  acbc_timer_state_type next;
  logic unit;

  always_comb begin
    next = cur;
    tmr.tick = tmr.use_internal ? (cur.div == TICK_LAST) : tmr.ext_fall;
    if (!tmr.use_internal || cur.div == TICK_LAST) begin
      next.div = 8'h00;
    end else begin
      next.div = cur.div + 8'h01;
    end
    unit = tmr.by_clock | tmr.tick;
    // kept free of load: the sequencer reloads on expiry, so a load term here would loop
    tmr.expired = unit && (cur.remain == 8'h01);
    if (tmr.load) begin
      next.remain = tmr.load_count;
    end else if (unit && cur.remain != 8'h00) begin
      next.remain = cur.remain - 8'h01;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cur <= '0;
    end else begin
      cur <= next;
    end
  end

  a_tick_spacing: assert property (@(posedge clk_in) disable iff (!resetn_in)
    tmr.use_internal && tmr.tick && $past(tmr.use_internal, TICK_CYC) |-> $past(tmr.tick, TICK_CYC))
    else $error("internal conversion tick off its period");
  a_load_count: assert property (@(posedge clk_in) disable iff (!resetn_in)
    tmr.load |=> cur.remain == $past(tmr.load_count))
    else $error("interval count not loaded");
endmodule

/* logic/acbc_control.sv */
// control word port and conversion sequencer of a successive-approximation converter
// assumes the analog core samples on track_out falling and steps on sar_step_out
//
// What this block does
// - power bits decode power-down, standby, internal, external
// - power-down words keep the previous clock mode
// - external clock mode selected after reset
// - acquisition style independent of clock source
// - acquisition bit 0 internal, 1 external
// - input-type bit 1 single-ended, 0 pseudo-differential
// - polarity bit 0 bipolar, 1 unipolar
// - three low bits address the channel
// - internal clock gives about 3.6 us conversion
// - one three-state bus carries words and the low result byte (result bits 7:0)
// - chip select high ignores pins, floats bus
// - control word latched from data lines
// - conversion lasts thirteen conversion-clock cycles
// - internal acquisition three ticks or one microsecond
// - done flag low on result, cleared on read/write
// - write during conversion aborts, starts new acquisition
`include "acbc_defs.svh"
module acbc_control
  import acbc_pkg::*;
#(
  parameter int unsigned TICK_CYC = `ACBC_TICK_CYC,
  parameter int unsigned ACQ_INT_CYC = `ACBC_ACQ_INT_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic cs_n_in,
  input wire logic wr_n_in,
  input wire logic rd_n_in,
  input wire logic conv_clk_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  input wire logic [9:0] sar_result_in,
  output logic conv_done_n_out,
  output logic [1:0] power_mode_out,
  output logic full_power_down_out,
  output logic standby_out,
  output logic clock_external_out,
  output logic acquisition_select_out,
  output logic single_ended_select_out,
  output logic unipolar_select_out,
  output logic [2:0] channel_addr_out,
  output logic track_out,
  output logic converting_out,
  output logic sar_step_out
);
  localparam logic [7:0] ACQ_INT_COUNT = 8'(ACQ_INT_CYC);
  localparam int unsigned PIN_CS = 0;
  localparam int unsigned PIN_WR = 1;
  localparam int unsigned PIN_RD = 2;
  localparam int unsigned PIN_CLK = 3;

  acbc_ctrl_state_type cur;
  acbc_ctrl_state_type next;
  acbc_timer_if tmr ();

  logic cs_active;
  logic wr_take;
  logic rd_fall;
  logic [7:0] wr_word;
  logic ext_fall;

  function automatic acbc_power_type acbc_power_decode(input logic [7:0] w);
    return acbc_power_type'(w[`ACBC_BIT_PD_HI:`ACBC_BIT_PD_LO]);
  endfunction

  function automatic logic acbc_is_run(input logic [7:0] w);
    return w[`ACBC_BIT_PD_HI];
  endfunction

  acbc_tick_timer #(
    .TICK_CYC(TICK_CYC)
  ) u_timer (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .tmr(tmr)
  );

  always_comb begin
    next = cur;
    // three-stage pin synchronisers; a level counts once stages two and three agree
    next.s0 = {conv_clk_in, rd_n_in, wr_n_in, cs_n_in};
    next.s1 = cur.s0;
    next.s2 = cur.s1;
    for (int i = 0; i < 4; i++) begin
      if (cur.s1[i] == cur.s2[i]) begin
        next.pins[i] = cur.s2[i];
      end
    end
    // data lines take the same delay, so the word lines up with the write edge
    next.d0 = data_in;
    next.d1 = cur.d0;
    next.d2 = cur.d1;

    cs_active = !cur.pins[PIN_CS];
    // with chip select high the strobes and the clock pin are not seen at all
    wr_take = cs_active && !cur.pins[PIN_WR] && next.pins[PIN_WR];
    rd_fall = cs_active && cur.pins[PIN_RD] && !next.pins[PIN_RD];
    ext_fall = cs_active && cur.pins[PIN_CLK] && !next.pins[PIN_CLK];
    wr_word = cur.d2;

    tmr.load = 1'b0;
    tmr.load_count = 8'h00;
    tmr.by_clock = 1'b0;
    tmr.use_internal = !cur.clock_external;
    tmr.ext_fall = ext_fall;

    next.dout = cur.result[7:0];

    if (rd_fall) begin
      next.done_n = 1'b1;
    end

    case (cur.phase)
      ACBC_ACQ_INT: begin
        // with the internal clock the acquisition is counted in system clocks all the way
        tmr.by_clock = !cur.clock_external;
        if (tmr.expired) begin
          next.phase = ACBC_CONVERT;
          tmr.load = 1'b1;
          tmr.load_count = `ACBC_CONV_STEPS;
        end
      end
      ACBC_CONVERT: begin
        if (tmr.expired) begin
          next.phase = ACBC_IDLE;
          next.result = sar_result_in;
          next.done_n = 1'b0;
        end
      end
      ACBC_IDLE: begin
      end
      ACBC_ACQ_EXT: begin
      end
      default: begin
        next.phase = ACBC_IDLE;
      end
    endcase

    // a write overrides whatever the sequencer was doing, a conversion included
    if (wr_take) begin
      next.word = wr_word;
      next.done_n = 1'b1;
      if (acbc_is_run(wr_word)) begin
        next.clock_external = wr_word[`ACBC_BIT_PD_LO];
      end
      if (cur.phase == ACBC_ACQ_EXT && !wr_word[`ACBC_BIT_ACQ]) begin
        next.phase = ACBC_CONVERT;
        tmr.load = 1'b1;
        tmr.load_count = `ACBC_CONV_STEPS;
      end else if (wr_word[`ACBC_BIT_ACQ]) begin
        next.phase = ACBC_ACQ_EXT;
      end else begin
        next.phase = ACBC_ACQ_INT;
        tmr.load = 1'b1;
        // acquisition is timed in clock cycles when the internal clock runs
        if (acbc_is_run(wr_word) ? !wr_word[`ACBC_BIT_PD_LO] : !cur.clock_external) begin
          tmr.by_clock = 1'b1;
          tmr.load_count = ACQ_INT_COUNT;
        end else begin
          tmr.load_count = `ACBC_ACQ_EXT_TICKS;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cur.s0 <= `ACBC_PINS_RESET;
      cur.s1 <= `ACBC_PINS_RESET;
      cur.s2 <= `ACBC_PINS_RESET;
      cur.pins <= `ACBC_PINS_RESET;
      cur.d0 <= 8'h00;
      cur.d1 <= 8'h00;
      cur.d2 <= 8'h00;
      cur.word <= `ACBC_WORD_RESET;
      cur.clock_external <= 1'b1;
      cur.phase <= ACBC_IDLE;
      cur.done_n <= 1'b1;
      cur.result <= 10'h000;
      cur.dout <= 8'h00;
    end else begin
      cur <= next;
    end
  end

  // results leave on the same lines the control word arrives on
  assign data_out = cur.dout;
  assign data_oe_out = cs_active && !cur.pins[PIN_RD];
  assign conv_done_n_out = cur.done_n;
  assign power_mode_out = cur.word[`ACBC_BIT_PD_HI:`ACBC_BIT_PD_LO];
  // power-down only takes hold once the sequencer is back in idle after the acquisition and conversion the power-down write starts
  assign full_power_down_out = (cur.phase == ACBC_IDLE) && (acbc_power_decode(cur.word) == ACBC_PD_FULL);
  assign standby_out = (cur.phase == ACBC_IDLE) && (acbc_power_decode(cur.word) == ACBC_PD_STANDBY);
  assign clock_external_out = cur.clock_external;
  assign acquisition_select_out = cur.word[`ACBC_BIT_ACQ];
  assign single_ended_select_out = cur.word[`ACBC_BIT_SGL];
  assign unipolar_select_out = cur.word[`ACBC_BIT_UNI];
  assign channel_addr_out = cur.word[`ACBC_ADDR_MSB:`ACBC_ADDR_LSB];
  assign track_out = (cur.phase == ACBC_ACQ_INT) || (cur.phase == ACBC_ACQ_EXT);
  assign converting_out = (cur.phase == ACBC_CONVERT);
  assign sar_step_out = converting_out && tmr.tick;

  // helper: conversion-clock steps seen in the present conversion
  logic [7:0] step_seen;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      step_seen <= 8'h00;
    end else if (!converting_out) begin
      step_seen <= 8'h00;
    end else if (sar_step_out) begin
      step_seen <= step_seen + 8'h01;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_ext_acq_open;
    wr_take && wr_word[`ACBC_BIT_ACQ];
  endsequence
  sequence s_ext_acq_close;
    wr_take && !wr_word[`ACBC_BIT_ACQ];
  endsequence

  a_clock_mode_set: assert property (wr_take && wr_word[`ACBC_BIT_PD_HI] |=>
    clock_external_out == $past(wr_word[`ACBC_BIT_PD_LO]))
    else $error("run word did not set clock mode");
  a_pd_keeps_clock: assert property (wr_take && !wr_word[`ACBC_BIT_PD_HI] |=> $stable(clock_external_out))
    else $error("power-down word changed clock mode");
  a_fields_latched: assert property (wr_take |=> power_mode_out == $past(wr_word[7:6]) &&
    channel_addr_out == $past(wr_word[2:0]) && single_ended_select_out == $past(wr_word[4]) &&
    unipolar_select_out == $past(wr_word[3]))
    else $error("control word not latched");
  a_bus_float: assert property (cur.pins[PIN_CS] |-> !data_oe_out && !wr_take)
    else $error("bus driven or write taken while deselected");
  a_ext_acq_start: assert property (s_ext_acq_open |=> track_out && acquisition_select_out)
    else $error("first write did not open external acquisition");
  a_ext_acq_pair: assert property ((track_out && acquisition_select_out) ##0 s_ext_acq_close
    |=> converting_out)
    else $error("second write did not start conversion");
  a_ext_acq_hold: assert property (track_out && acquisition_select_out && !wr_take |=> track_out)
    else $error("external acquisition ended without a write");
  a_conv_steps: assert property (converting_out && tmr.expired |-> step_seen == 8'h0C)
    else $error("conversion not thirteen steps long");
  a_int_acq_ends: assert property (cur.phase == ACBC_ACQ_INT && tmr.expired && !wr_take |=>
    converting_out && !track_out)
    else $error("internal acquisition did not hand over");
  a_done_clear: assert property (wr_take || (rd_fall && !(converting_out && tmr.expired)) |=> conv_done_n_out)
    else $error("done flag not cleared by read or write");
  a_done_set: assert property (converting_out && tmr.expired && !wr_take |=>
    !conv_done_n_out && cur.result == $past(sar_result_in))
    else $error("done flag not set with result");
  a_abort_conv: assert property (converting_out && wr_take |=> track_out)
    else $error("write did not abort conversion");
endmodule

/* dv/acbc_host_model.sv */
// host processor model: chip select, write and read strobes, clock pin, data lines
// assumes the bench resolves the data bus from this model and the device
module acbc_host_model (
  input wire logic clk_in,
  output logic cs_n_out,
  output logic wr_n_out,
  output logic rd_n_out,
  output logic conv_clk_out,
  output logic [7:0] data_out,
  output logic data_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cs_n_out = 1'b1;
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    conv_clk_out = 1'b0; // pin held low whenever no clock is wanted
    data_out = 8'hFF;
    data_oe_out = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic select(input logic v);
    cs_n_out = v;
    step(4);
  endtask
  // word stands 8 clk before and 2 clk after the strobe rise for the pin filters
  task automatic write_word(input logic [7:0] w);
    data_out = w;
    data_oe_out = 1'b1;
    step(4);
    wr_n_out = 1'b0;
    step(4);
    wr_n_out = 1'b1;
    step(2);
    data_oe_out = 1'b0;
    data_out = ~w; // a released bus has no pull, so it must not keep the last value
    step(3);
  endtask
  task automatic set_read(input logic v);
    rd_n_out = v;
  endtask
  // 20 clk period is 6.25 MHz at 50 % duty
  task automatic ext_clocks(input int n);
    repeat (n) begin
      conv_clk_out = 1'b1;
      step(10);
      conv_clk_out = 1'b0;
      step(10);
    end
  endtask
endmodule

/* dv/tb_top.sv */
// self-checking bench of the converter control block
// assumes the design is compiled with its package, interface and header
module tb_top;
  import acbc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic cs_n, wr_n, rd_n, cclk, hoe, oe, done_n, fpd, stby, clk_ext, acq, sgl, uni, track, conv, sar_step;
  logic [7:0] hdata, ddata, bus;
  logic [1:0] pmode;
  logic [2:0] ch;
  logic [9:0] sar_val = 10'h000;
  int fails = 0;
  int checks_done = 0;
  int acq_len, conv_len, steps;
  always #4 clk_in = ~clk_in;
  assign bus = oe ? ddata : hdata;
  acbc_host_model i_acbc_host_model (.clk_in(clk_in), .cs_n_out(cs_n), .wr_n_out(wr_n), .rd_n_out(rd_n),
    .conv_clk_out(cclk), .data_out(hdata), .data_oe_out(hoe));
  // short tick and acquisition counts keep the run brief
  acbc_control #(.TICK_CYC(4), .ACQ_INT_CYC(6)) i_acbc_control (.clk_in(clk_in), .resetn_in(resetn_in),
    .cs_n_in(cs_n), .wr_n_in(wr_n), .rd_n_in(rd_n), .conv_clk_in(cclk), .data_in(bus), .data_out(ddata),
    .data_oe_out(oe), .sar_result_in(sar_val), .conv_done_n_out(done_n), .power_mode_out(pmode),
    .full_power_down_out(fpd), .standby_out(stby), .clock_external_out(clk_ext),
    .acquisition_select_out(acq), .single_ended_select_out(sgl), .unipolar_select_out(uni),
    .channel_addr_out(ch), .track_out(track), .converting_out(conv), .sar_step_out(sar_step));
  // counted mid-cycle, where the registered outputs have settled
  always @(negedge clk_in) begin
    if (track === 1'b1) acq_len++;
    if (conv === 1'b1) conv_len++;
    if (sar_step === 1'b1) steps++;
    if (oe === 1'b1 && hoe === 1'b1) begin
      fails++;
      $display("MISMATCH bus ownership expected 0 seen 1");
    end
  end
  task automatic conclude();
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = track;
      1: pick = conv;
      2: pick = done_n;
      default: pick = oe;
    endcase
  endfunction
  task automatic wait_sig(input int sel, input logic v);
    int n;
    n = 0;
    while (pick(sel) !== v) begin
      if (n++ > 3000) begin
        fails++;
        conclude();
      end
      i_acbc_host_model.step(1);
    end
  endtask
  task automatic t_reset();
    check("reset modes", 8'hF0, {pmode, clk_ext, done_n, oe, track, conv, sar_step});
    check("reset data", 8'h00, ddata);
  endtask
  task automatic t_deselected();
    i_acbc_host_model.write_word(8'h00);
    check("deselected write", 8'h07, {pmode, clk_ext});
    i_acbc_host_model.set_read(1'b0);
    i_acbc_host_model.step(6);
    check("deselected read oe", 8'h00, oe);
    i_acbc_host_model.set_read(1'b1);
    i_acbc_host_model.select(1'b0);
  endtask
  task automatic t_modes();
    logic [7:0] words [6] = '{8'hBA, 8'h25, 8'h7F, 8'hE3, 8'h21, 8'hAC};
    logic exp_ext;
    exp_ext = 1'b1;
    foreach (words[i]) begin
      i_acbc_host_model.write_word(words[i]);
      if (words[i][7]) exp_ext = words[i][6];
      check("mode fields", words[i], {pmode, acq, sgl, uni, ch});
      check("clock mode", exp_ext, clk_ext);
    end
  endtask
  task automatic t_ext_acq();
    i_acbc_host_model.write_word(8'hA0);
    i_acbc_host_model.step(200);
    check("external acquisition holds", 8'h02, {track, conv});
    i_acbc_host_model.write_word(8'h80);
    wait_sig(1, 1'b1);
    wait_sig(2, 1'b0);
  endtask
  task automatic t_conv_int();
    acq_len = 0;
    conv_len = 0;
    steps = 0;
    sar_val = 10'h2A5;
    i_acbc_host_model.write_word(8'h80);
    check("done cleared by write", 8'h01, done_n);
    wait_sig(2, 1'b0);
    check("internal acquisition length", 8'h01, {7'h00, acq_len inside {[5:8]}});
    check("conversion length", 8'h01, {7'h00, conv_len inside {[48:53]}});
    check("steps", 8'h0D, steps[7:0]);
    read_check(8'hA5);
  endtask
  task automatic read_check(input logic [7:0] exp);
    i_acbc_host_model.set_read(1'b0);
    wait_sig(3, 1'b1);
    i_acbc_host_model.step(1);
    check("read data", exp, ddata);
    check("done cleared by read", 8'h01, done_n);
    i_acbc_host_model.set_read(1'b1);
    wait_sig(3, 1'b0);
  endtask
  task automatic t_conv_ext();
    steps = 0;
    sar_val = 10'h15A;
    i_acbc_host_model.write_word(8'hC3);
    i_acbc_host_model.ext_clocks(2);
    check("acquiring after two clocks", 8'h02, {track, conv});
    i_acbc_host_model.ext_clocks(1);
    check("converting after three clocks", 8'h01, {track, conv});
    i_acbc_host_model.ext_clocks(13);
    check("done after thirteen", 8'h00, done_n);
    check("external steps", 8'h0D, steps[7:0]);
    read_check(8'h5A);
  endtask
  task automatic t_power();
    i_acbc_host_model.write_word(8'h01);
    check("power-down waits for idle", 8'h00, {fpd, stby});
    wait_sig(2, 1'b0);
    check("full power-down", 8'h04, {fpd, stby, clk_ext});
    i_acbc_host_model.write_word(8'h41);
    wait_sig(2, 1'b0);
    check("standby", 8'h02, {fpd, stby, clk_ext});
  endtask
  task automatic t_abort();
    i_acbc_host_model.write_word(8'h80);
    wait_sig(1, 1'b1);
    i_acbc_host_model.write_word(8'h80);
    check("abort restarts acquisition", 8'h02, {track, conv});
    wait_sig(2, 1'b0);
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    i_acbc_host_model.step(2);
    t_reset();
    t_deselected();
    t_modes();
    t_ext_acq();
    t_conv_int();
    t_conv_ext();
    t_abort();
    t_power();
    conclude();
  end
endmodule
